// File: cfgl_pkg.sv
// Purpose: Shared constants and types for the configuration load port.
// Assumes: Reference clock of 50 MHz.
// Notes: Times are kept in ns and turned into cycle counts here.
package cfgl_pkg;
	localparam int REF_MHZ = 50;
	// Half periods of the generated configuration clock, in ref cycles.
	localparam logic [5:0] HALF_FAST = 6'h04;
	localparam logic [5:0] HALF_SLOW = 6'h20;
	// Delays from init high to the first configuration clock edge.
	localparam int T_ICLK_MSF_NS = 500;
	localparam int T_ICLK_MSS_NS = 1000;
	localparam int T_ICLK_MPF_NS = 1000;
	localparam int T_ICLK_MPS_NS = 4800;
	localparam logic [7:0] ICLK_MSF_CYC =
		8'((T_ICLK_MSF_NS * REF_MHZ + 999) / 1000);
	localparam logic [7:0] ICLK_MSS_CYC =
		8'((T_ICLK_MSS_NS * REF_MHZ + 999) / 1000);
	localparam logic [7:0] ICLK_MPF_CYC =
		8'((T_ICLK_MPF_NS * REF_MHZ + 999) / 1000);
	localparam logic [7:0] ICLK_MPS_CYC =
		8'((T_ICLK_MPS_NS * REF_MHZ + 999) / 1000);
	// Memory clear time before init is released.
	localparam int T_INIT_LAT_NS = 210000;
	localparam int INIT_LAT_CYC = (T_INIT_LAT_NS * REF_MHZ + 999) / 1000;
	localparam logic [2:0] STRB_RISE_PH = 3'h6;
	localparam logic [2:0] STRB_FALL_PH = 3'h7;
	localparam int ADDR_W = 18;
	localparam logic [17:0] ADDR_RST = 18'h00000;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 4;

	typedef enum logic [1:0] {
		MODE_MS = 2'b00,
		MODE_MP = 2'b01,
		MODE_AP = 2'b10,
		MODE_SS = 2'b11
	} cfgl_mode_t;

	typedef enum logic [1:0] {
		ST_CLEAR = 2'b00,
		ST_WAIT = 2'b01,
		ST_DELAY = 2'b10,
		ST_RUN = 2'b11
	} cfgl_state_t;

	typedef struct packed {
		logic wr_b;
		logic rd_b;
		logic cs_a_b;
		logic cs_b;
	} cfgl_host_t;

	typedef struct packed {
		logic prog_b;
		logic init;
		logic din;
		logic rate;
		logic [1:0] mode;
		cfgl_host_t host;
		logic [7:0] data;
	} cfgl_pins_t;
endpackage

// File: cfgl_top.sv
// Purpose: Configuration load port: master serial, master parallel,
//   asynchronous peripheral and slave serial loading.
// Assumes: Slave serial clock arrives on lnk_clk_i; all other pins are
//   asynchronous to ref_clk_i and are synchronised first.
// Notes: Loaded bytes leave through a small FIFO on cfg_byte_o.
// What this block does
// - Forward serial bit on next falling clock.
// - Master serial samples input on rising edge.
// - Master serial clock rate follows rate pin.
// - Read strobe: seven clocks low, one high.
// - New address after strobe falls; capture at rise.
// - Parallel byte shifts out 1.5 clocks later.
// - Peripheral byte shifts out at falling edge.
// - Ready shown on pin and data bit 7.
// - Read strobe drives only data bit 7.
// - Master clock starts delayed after init rises.
// - Program release: clear, then raise init.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module cfgl_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= '0;
			q_o <= '0;
		end else begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////
module cfgl_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wptr_ff;
	logic [AW:0] rptr_ff;
	logic full;
	assign full = (wptr_ff[AW] != rptr_ff[AW]) &&
		(wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
	assign in_ready_o = !full;
	assign out_valid_o = (wptr_ff != rptr_ff);
	assign out_data_o = mem[rptr_ff[AW-1:0]];
	always_ff @(posedge clk_i) begin
		if (in_valid_i && !full) begin
			mem[wptr_ff[AW-1:0]] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			if (in_valid_i && !full) begin
				wptr_ff <= wptr_ff + 1'b1;
			end
			if (out_valid_o && out_ready_i) begin
				rptr_ff <= rptr_ff + 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////
module cfgl_top import cfgl_pkg::*; #(
	parameter int INIT_LAT = INIT_LAT_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic lnk_clk_i,
	input wire logic program_pin_b_i,
	input wire logic [1:0] mode_i,
	input wire logic rate_select_pin_i,
	input wire logic init_i,
	output logic init_o,
	output logic init_oe_o,
	output logic mem_clear_o,
	output logic cfg_clk_o,
	input wire logic din_i,
	output logic dout_o,
	output logic rd_strobe_o,
	output logic [ADDR_W-1:0] addr_o,
	input wire logic [7:0] data_i,
	input wire logic wr_b_i,
	input wire logic rd_b_i,
	input wire logic chip_sel_a_b_i,
	input wire logic chip_sel_b_i,
	output logic rdy_o,
	output logic status_data_bit_o,
	output logic status_data_bit_oe_o,
	output logic [7:0] cfg_byte_o,
	output logic cfg_valid_o,
	input wire logic cfg_ready_i
);
	logic rst_sync_b;
	logic lnk_rst_b;
	cfgl_pins_t pins_raw;
	cfgl_pins_t pins_s;
	cfgl_pins_t pins_p_ff;
	cfgl_state_t state_ff;
	cfgl_mode_t mode_ff;
	logic rate_ff;
	logic [13:0] clr_cnt_ff;
	logic [7:0] dly_cnt_ff;
	logic [7:0] dly_tgt;
	logic [5:0] half;
	logic [5:0] half_cnt_ff;
	logic cfg_clk_ff;
	logic run;
	logic rise_ev;
	logic fall_ev;
	logic fifo_in_rdy;
	logic push_v;
	logic [7:0] push_d;
	logic cap_ff;
	logic [7:0] asm_ff;
	logic [2:0] bcnt_ff;
	logic [2:0] ph_ff;
	logic strb_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [7:0] pend_ff;
	logic [1:0] pdly_ff;
	logic [7:0] sh_ff;
	logic [2:0] shcnt_ff;
	logic dout_ff;
	logic rdy_int;
	logic accept;
	logic mp_cap;
	logic tog_s;
	logic tog_p_ff;
	logic lnk_bit_ff;
	logic [6:0] lnk_asm_ff;
	logic [2:0] lnk_cnt_ff;
	logic [7:0] lnk_byte_ff;
	logic lnk_tog_ff;
	logic lnk_dout_ff;

	cfgl_sync #(.W(1)) u_rst_sync (.clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.d_i(1'b1), .q_o(rst_sync_b));
	cfgl_sync #(.W(1)) u_lnk_rst (.clk_i(lnk_clk_i), .rst_b_i(rst_b_i),
		.d_i(1'b1), .q_o(lnk_rst_b));
	assign pins_raw = '{prog_b: program_pin_b_i, init: init_i, din: din_i,
		rate: rate_select_pin_i, mode: mode_i,
		host: '{wr_b: wr_b_i, rd_b: rd_b_i, cs_a_b: chip_sel_a_b_i,
		cs_b: chip_sel_b_i}, data: data_i};
	cfgl_sync #(.W($bits(cfgl_pins_t))) u_pin_sync (.clk_i(ref_clk_i),
		.rst_b_i(rst_sync_b), .d_i(pins_raw), .q_o(pins_s));
	cfgl_sync #(.W(1)) u_tog_sync (.clk_i(ref_clk_i), .rst_b_i(rst_sync_b),
		.d_i(lnk_tog_ff), .q_o(tog_s));

	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pins_p_ff <= '0;
			tog_p_ff <= 1'b0;
		end else begin
			pins_p_ff <= pins_s;
			tog_p_ff <= tog_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave serial link: the upstream device owns this clock.
	always_ff @(posedge lnk_clk_i or negedge lnk_rst_b) begin
		if (!lnk_rst_b) begin
			lnk_bit_ff <= 1'b0;
			lnk_asm_ff <= '0;
			lnk_cnt_ff <= '0;
			lnk_byte_ff <= '0;
			lnk_tog_ff <= 1'b0;
		end else begin
			lnk_bit_ff <= din_i;
			lnk_asm_ff <= {lnk_asm_ff[5:0], din_i};
			lnk_cnt_ff <= lnk_cnt_ff + 3'h1;
			// The byte stays put for eight link clocks, long enough for
			// the toggle to cross before it is overwritten.
			if (lnk_cnt_ff == 3'h7) begin
				lnk_byte_ff <= {lnk_asm_ff, din_i};
				lnk_tog_ff <= ~lnk_tog_ff;
			end
		end
	end

	always_ff @(negedge lnk_clk_i or negedge lnk_rst_b) begin
		if (!lnk_rst_b) begin
			lnk_dout_ff <= 1'b0;
		end else begin
			lnk_dout_ff <= lnk_bit_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (mode_ff)
			MODE_MS: dly_tgt = rate_ff ? ICLK_MSS_CYC : ICLK_MSF_CYC;
			MODE_MP: dly_tgt = rate_ff ? ICLK_MPS_CYC : ICLK_MPF_CYC;
			default: dly_tgt = ICLK_MSF_CYC;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state_ff <= ST_CLEAR;
			clr_cnt_ff <= '0;
			dly_cnt_ff <= '0;
			mode_ff <= MODE_MS;
			rate_ff <= 1'b0;
		end else if (!pins_s.prog_b) begin
			state_ff <= ST_CLEAR;
			clr_cnt_ff <= '0;
		end else begin
			case (state_ff)
				ST_CLEAR: begin
					clr_cnt_ff <= clr_cnt_ff + 14'h0001;
					if (clr_cnt_ff == 14'(INIT_LAT - 1)) begin
						state_ff <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Another device may still hold init low.
					if (pins_s.init) begin
						mode_ff <= cfgl_mode_t'(pins_s.mode);
						rate_ff <= pins_s.rate;
						dly_cnt_ff <= '0;
						state_ff <= ST_DELAY;
					end
				end
				ST_DELAY: begin
					dly_cnt_ff <= dly_cnt_ff + 8'h01;
					if (dly_cnt_ff == dly_tgt - 8'h01) begin
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: state_ff <= ST_RUN;
				default: state_ff <= ST_CLEAR;
			endcase
		end
	end

	assign init_o = 1'b0;
	assign init_oe_o = (state_ff == ST_CLEAR);
	assign mem_clear_o = (state_ff == ST_CLEAR);

	////////////////////////////////////////////////////////////////////////
	// A full FIFO freezes the configuration clock, which only stretches it.
	assign half = (rate_ff && mode_ff != MODE_AP) ? HALF_SLOW : HALF_FAST;
	assign run = (state_ff == ST_RUN) && (mode_ff != MODE_SS) && fifo_in_rdy;
	assign rise_ev = run && (half_cnt_ff == half - 6'h01) && !cfg_clk_ff;
	assign fall_ev = run && (half_cnt_ff == half - 6'h01) && cfg_clk_ff;

	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			half_cnt_ff <= '0;
			cfg_clk_ff <= 1'b0;
		end else if (state_ff != ST_RUN) begin
			half_cnt_ff <= '0;
			cfg_clk_ff <= 1'b0;
		end else if (run) begin
			if (half_cnt_ff == half - 6'h01) begin
				half_cnt_ff <= '0;
				cfg_clk_ff <= ~cfg_clk_ff;
			end else begin
				half_cnt_ff <= half_cnt_ff + 6'h01;
			end
		end
	end

	assign cfg_clk_o = cfg_clk_ff;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cap_ff <= 1'b0;
			asm_ff <= '0;
			bcnt_ff <= '0;
		end else if (state_ff != ST_RUN) begin
			// Each new load frames its bytes from its own first bit.
			asm_ff <= '0;
			bcnt_ff <= '0;
		end else if (rise_ev && mode_ff == MODE_MS) begin
			cap_ff <= pins_s.din;
			asm_ff <= {asm_ff[6:0], pins_s.din};
			bcnt_ff <= bcnt_ff + 3'h1;
		end
	end

	assign mp_cap = rise_ev && (mode_ff == MODE_MP) && (ph_ff == STRB_RISE_PH);

	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ph_ff <= '0;
			strb_ff <= 1'b0;
			addr_ff <= ADDR_RST;
		end else if (state_ff != ST_RUN) begin
			ph_ff <= '0;
			strb_ff <= 1'b0;
			addr_ff <= ADDR_RST;
		end else if (rise_ev && mode_ff == MODE_MP) begin
			ph_ff <= ph_ff + 3'h1;
			strb_ff <= (ph_ff == STRB_RISE_PH);
			if (ph_ff == STRB_FALL_PH) begin
				addr_ff <= addr_ff + 18'h00001;
			end
		end
	end

	assign rd_strobe_o = strb_ff;
	assign addr_o = addr_ff;

	// The host has no data hold time, so the byte seen a cycle earlier
	// is taken when the write strobe ends.
	assign rdy_int = (state_ff == ST_RUN) && (mode_ff == MODE_AP) &&
		(pdly_ff == 2'h0) && (shcnt_ff == 3'h0) && fifo_in_rdy;
	assign accept = rdy_int && pins_s.host.wr_b && !pins_p_ff.host.wr_b &&
		!pins_p_ff.host.cs_a_b && pins_p_ff.host.cs_b;
	assign rdy_o = rdy_int;
	assign status_data_bit_o = rdy_int;
	assign status_data_bit_oe_o = (state_ff == ST_RUN) &&
		(mode_ff == MODE_AP) && !pins_s.host.rd_b &&
		!pins_s.host.cs_a_b && pins_s.host.cs_b;

	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pend_ff <= '0;
			pdly_ff <= '0;
		end else if (state_ff != ST_RUN) begin
			pdly_ff <= '0;
		end else if (mp_cap) begin
			pend_ff <= pins_s.data;
			pdly_ff <= 2'h2;
		end else if (accept) begin
			pend_ff <= pins_p_ff.data;
			pdly_ff <= 2'h1;
		end else if (fall_ev && pdly_ff != 2'h0) begin
			pdly_ff <= pdly_ff - 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sh_ff <= '0;
			shcnt_ff <= '0;
			dout_ff <= 1'b0;
		end else if (state_ff != ST_RUN) begin
			// A cut load must not leave bits queued for the next mode.
			shcnt_ff <= '0;
		end else if (fall_ev) begin
			if (mode_ff == MODE_MS) begin
				dout_ff <= cap_ff;
			end else if (pdly_ff == 2'h1) begin
				dout_ff <= pend_ff[7];
				sh_ff <= {pend_ff[6:0], 1'b0};
				shcnt_ff <= 3'h7;
			end else if (shcnt_ff != 3'h0) begin
				dout_ff <= sh_ff[7];
				sh_ff <= {sh_ff[6:0], 1'b0};
				shcnt_ff <= shcnt_ff - 3'h1;
			end
		end
	end

	assign dout_o = (mode_ff == MODE_SS) ? lnk_dout_ff : dout_ff;

	////////////////////////////////////////////////////////////////////////
	// Slave serial cannot be stalled; a byte arriving at a full FIFO is lost.
	always_comb begin
		push_v = 1'b0;
		push_d = pins_s.data;
		case (mode_ff)
			MODE_MS: begin
				push_v = rise_ev && (bcnt_ff == 3'h7);
				push_d = {asm_ff[6:0], pins_s.din};
			end
			MODE_MP: push_v = mp_cap;
			MODE_AP: begin
				push_v = accept;
				push_d = pins_p_ff.data;
			end
			MODE_SS: begin
				push_v = (state_ff == ST_RUN) && (tog_s != tog_p_ff);
				push_d = lnk_byte_ff;
			end
			default: push_v = 1'b0;
		endcase
	end

	cfgl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.clk_i(ref_clk_i),
		.rst_b_i(rst_sync_b),
		.in_valid_i(push_v),
		.in_data_i(push_d),
		.in_ready_o(fifo_in_rdy),
		.out_valid_o(cfg_valid_o),
		.out_data_o(cfg_byte_o),
		.out_ready_i(cfg_ready_i)
	);

	////////////////////////////////////////////////////////////////////////
	logic [6:0] per_cnt_ff;
	logic per_ok_ff;
	logic [3:0] low_cnt_ff;
	always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			per_cnt_ff <= '0;
			per_ok_ff <= 1'b0;
			low_cnt_ff <= 4'h1;
		end else if (state_ff != ST_RUN) begin
			per_cnt_ff <= '0;
			per_ok_ff <= 1'b0;
			low_cnt_ff <= 4'h1;
		end else begin
			if (rise_ev) begin
				per_cnt_ff <= '0;
				per_ok_ff <= 1'b1;
				low_cnt_ff <= strb_ff ? 4'h1 : low_cnt_ff + 4'h1;
			end else if (run) begin
				per_cnt_ff <= per_cnt_ff + 7'h01;
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_sync_b);

	sequence mp_cap_s;
		mp_cap;
	endsequence
	sequence ap_acc_s;
		accept;
	endsequence
	sequence strb_hold_s;
		rd_strobe_o && state_ff == ST_RUN && pins_s.prog_b;
	endsequence

	clk_period_a: assert property (rise_ev && per_ok_ff |->
		per_cnt_ff == 7'({half, 1'b0} - 7'h01))
		else $error("configuration clock period wrong");
	ms_sample_a: assert property (rise_ev && mode_ff == MODE_MS |=>
		cap_ff == $past(pins_s.din))
		else $error("master serial bit not sampled at rise");
	ms_forward_a: assert property (fall_ev && mode_ff == MODE_MS |=>
		dout_o == $past(cap_ff))
		else $error("serial bit not forwarded at fall");
	strobe_low_a: assert property ($rose(rd_strobe_o) |->
		$past(low_cnt_ff) == 4'h7)
		else $error("read strobe low time not seven clocks");
	strobe_high_a: assert property (strb_hold_s |=>
		rd_strobe_o == !$past(rise_ev))
		else $error("read strobe high time wrong");
	addr_step_a: assert property ($fell(rd_strobe_o) &&
		state_ff == ST_RUN |-> addr_o == $past(addr_o) + 18'h00001)
		else $error("address not advanced after strobe fall");
	mp_start_a: assert property (mp_cap_s |=>
		pdly_ff == 2'h2 && pend_ff == $past(pins_s.data))
		else $error("parallel byte not scheduled for 1.5 clocks");
	ap_start_a: assert property (ap_acc_s |=> pdly_ff == 2'h1)
		else $error("peripheral byte not scheduled at next fall");
	ap_rdy_low_a: assert property (ap_acc_s |=> !rdy_o [*2])
		else $error("ready not low after accepted write");
	d7_status_a: assert property (status_data_bit_oe_o |->
		status_data_bit_o == rdy_o)
		else $error("status bit differs from ready");
	d7_only_a: assert property (status_data_bit_oe_o |->
		mode_ff == MODE_AP && !pins_s.host.rd_b)
		else $error("status bit driven outside read strobe");
	cfg_clk_delay_a: assert property ($rose(state_ff == ST_RUN) |->
		$past(dly_cnt_ff) == dly_tgt - 8'h01)
		else $error("clock start delay wrong");
	init_lat_a: assert property ($fell(init_oe_o) && pins_s.prog_b |->
		$past(clr_cnt_ff) == 14'(INIT_LAT - 1))
		else $error("init released at wrong time");
endmodule

// File: cfgl_far_model.sv
// Purpose: Far-side model holding a serial ROM and a parallel memory.
// Assumes: The ROM restarts from bit 0 while init is held low.
// Notes: The memory answers from the address alone, like an async part.
`timescale 1ns/100ps
module cfgl_far_model import cfgl_pkg::*; (
	input wire logic cfg_clk_i,
	input wire logic init_i,
	input wire logic [ADDR_W-1:0] addr_i,
	output logic din_o,
	output logic [7:0] data_o
);
	logic [9:0] bit_ff;
	logic [7:0] rom_byte;

	////////////////////////////////////////////////////////////////////
	// The next bit is put out at each fall, a half period before the
	// rise that samples it, so slow sync paths still see it settled.
	always_ff @(negedge cfg_clk_i or negedge init_i) begin
		if (!init_i) begin
			bit_ff <= 10'h000;
		end else begin
			bit_ff <= bit_ff + 10'h001;
		end
	end
	assign rom_byte = 8'h96 ^ {1'b0, bit_ff[9:3]};
	assign din_o = rom_byte[3'h7 - bit_ff[2:0]];

	////////////////////////////////////////////////////////////////////
	assign data_o = addr_i[7:0] ^ 8'hC3;
endmodule

// File: config_load_port_timing_bench.sv
// Purpose: Self-checking bench for the configuration load port.
// Assumes: Init wire has a pull-up; the link clock runs only in frames.
// Notes: The clear latency is shortened to keep the run brief.
`timescale 1ns/100ps
module config_load_port_timing_bench import cfgl_pkg::*;;
	localparam int LAT = 20;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic lnk_clk_i = 1'b0;
	logic prog_b = 1'b1;
	logic [1:0] mode = 2'b00;
	logic rate = 1'b0;
	logic ss_din = 1'b0;
	logic wr_b = 1'b1;
	logic rd_b = 1'b1;
	logic csa_b = 1'b1;
	logic csb = 1'b0;
	logic cfg_ready = 1'b1;
	logic [7:0] hdata = 8'h00;
	logic init_oe, mem_clr, cfg_clk, dout, strb, rdy, st_bit, st_oe;
	logic valid, init_w, rom_din, din, init_drv;
	logic [ADDR_W-1:0] addr;
	logic [7:0] byte_o, mdata, data;
	logic [7:0] got[$];
	int fail_count = 0;
	int n_checks = 0;

	initial begin
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	assign init_w = init_oe ? init_drv : 1'b1;
	assign din = (mode == MODE_SS) ? ss_din : rom_din;
	assign data = (mode == MODE_AP) ? hdata : mdata;
	always @(posedge ref_clk_i) begin
		if (valid === 1'b1 && cfg_ready === 1'b1) begin
			got.push_back(byte_o);
		end
	end

	cfgl_top #(.INIT_LAT(LAT)) DUT (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .lnk_clk_i(lnk_clk_i),
		.program_pin_b_i(prog_b), .mode_i(mode),
		.rate_select_pin_i(rate), .init_i(init_w), .init_o(init_drv),
		.init_oe_o(init_oe), .mem_clear_o(mem_clr), .cfg_clk_o(cfg_clk),
		.din_i(din), .dout_o(dout), .rd_strobe_o(strb), .addr_o(addr),
		.data_i(data), .wr_b_i(wr_b), .rd_b_i(rd_b),
		.chip_sel_a_b_i(csa_b), .chip_sel_b_i(csb), .rdy_o(rdy),
		.status_data_bit_o(st_bit), .status_data_bit_oe_o(st_oe),
		.cfg_byte_o(byte_o), .cfg_valid_o(valid),
		.cfg_ready_i(cfg_ready));
	cfgl_far_model FAR (.cfg_clk_i(cfg_clk), .init_i(init_w),
		.addr_i(addr), .din_o(rom_din), .data_o(mdata));

	////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] a);
		n_checks++;
		if (a !== e) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", nm, e, a);
		end
	endtask
	function automatic logic sig(input int k);
		case (k)
			0: return cfg_clk;
			1: return init_oe;
			2: return strb;
			default: return rdy;
		endcase
	endfunction
	// Level waits sample 1 ns after the edge so that its updates landed.
	task automatic wt(input int k, input logic v, input int lim,
		output int n);
		n = 0;
		while (sig(k) !== v) begin
			@(posedge ref_clk_i);
			#1;
			n++;
			if (n > lim) begin
				chk("wait", 1, 0);
				print_verdict();
			end
		end
	endtask
	task automatic fall();
		logic c;
		int n;
		n = 0;
		do begin
			c = cfg_clk;
			@(posedge ref_clk_i);
			#1;
			n++;
			if (n > 300) begin
				chk("cfg_clk fall", 1, 0);
				print_verdict();
			end
		end while (!(c === 1'b1 && cfg_clk === 1'b0));
	endtask
	function automatic logic [7:0] rom(input int j);
		return 8'h96 ^ 8'(j);
	endfunction

	////////////////////////////////////////////////////////////////////
	task automatic st(input logic [1:0] m, input logic r, input int mn,
		input int mx);
		int n;
		@(posedge ref_clk_i);
		prog_b <= 1'b0;
		mode <= m;
		rate <= r;
		repeat (5) @(posedge ref_clk_i);
		prog_b <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk("mem_clear", 1, mem_clr);
		wt(1, 1'b0, LAT + 10, n);
		chk("clear_len", 1, n >= LAT - 4 && n <= LAT);
		got.delete();
		if (mx > 0) begin
			wt(0, 1'b1, 400, n);
			chk("start_dly", 1, n >= mn && n <= mx);
		end
	endtask
	task automatic ms(input logic r);
		int n;
		logic [7:0] b;
		st(MODE_MS, r, r ? ICLK_MSS_CYC : ICLK_MSF_CYC, r ? 400 : 103);
		wt(0, 1'b0, 100, n);
		chk("half_period", r ? HALF_SLOW : HALF_FAST, n);
		chk("dout", rom(0) >> 7, dout);
		for (int k = 1; k < 16; k++) begin
			fall();
			b = rom(k / 8);
			chk("dout", b[7 - k % 8], dout);
		end
		repeat (20) @(posedge ref_clk_i);
		chk("byte0", rom(0), got[0]);
		chk("byte1", rom(1), got[1]);
	endtask
	task automatic mp();
		int n;
		int t;
		logic c;
		st(MODE_MP, 0, ICLK_MPF_CYC, 400);
		// Stall only now, so no byte of the previous load is held back.
		@(posedge ref_clk_i);
		cfg_ready <= 1'b0;
		wt(2, 1'b1, 200, n);
		fall();
		fall();
		chk("dout_b7", 8'hC3 >> 7, dout);
		chk("addr", 1, addr);
		wt(2, 1'b1, 200, n);
		wt(2, 1'b0, 200, n);
		chk("strb_high", 2 * HALF_FAST, n);
		chk("addr", 2, addr);
		wt(2, 1'b1, 200, n);
		chk("strb_low", 14 * HALF_FAST, n);
		repeat (600) @(posedge ref_clk_i);
		t = 0;
		c = cfg_clk;
		for (int i = 0; i < 200; i++) begin
			@(posedge ref_clk_i);
			t += (cfg_clk !== c);
			c = cfg_clk;
		end
		chk("stall", 0, t);
		cfg_ready <= 1'b1;
		repeat (300) @(posedge ref_clk_i);
		for (int j = 0; j < 4; j++) begin
			chk("mp_byte", 8'(j) ^ 8'hC3, got[j]);
		end
	endtask
	task automatic mps();
		int n;
		st(MODE_MP, 1, ICLK_MPS_CYC, 400);
		wt(2, 1'b1, 400, n);
		chk("strb_first", 12 * HALF_SLOW, n);
		wt(2, 1'b0, 100, n);
		chk("strb_high_slow", 2 * HALF_SLOW, n);
	endtask
	task automatic wr(input logic [7:0] d);
		int n;
		wt(3, 1'b1, 40, n);
		@(posedge ref_clk_i);
		hdata <= d;
		wr_b <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		fall();
		@(posedge ref_clk_i);
		wr_b <= 1'b1;
		wt(3, 1'b0, 6, n);
		chk("status_bit", 0, st_bit);
		for (int k = 7; k >= 0; k--) begin
			fall();
			chk("ap_dout", d[k], dout);
		end
		wt(3, 1'b1, 20, n);
	endtask
	task automatic ap();
		st(MODE_AP, 0, 0, 0);
		repeat (100) @(posedge ref_clk_i);
		csa_b <= 1'b0;
		csb <= 1'b1;
		wr(8'hB4);
		wr(8'h6D);
		@(posedge ref_clk_i);
		rd_b <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk("d7_oe", 1, st_oe);
		chk("rdy", 1, rdy);
		chk("status_bit", 1, st_bit);
		@(posedge ref_clk_i);
		rd_b <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		#1;
		chk("d7_oe", 0, st_oe);
		chk("ap_byte0", 8'hB4, got[0]);
		chk("ap_byte1", 8'h6D, got[1]);
	endtask
	// The first two link pulses only lift the link domain out of reset.
	task automatic ss();
		logic [9:0] v;
		st(MODE_SS, 0, 0, 0);
		// A byte crossing before the port runs would be dropped.
		repeat (40) @(posedge ref_clk_i);
		v = 10'h0C9;
		#3;
		for (int k = 9; k >= 0; k--) begin
			ss_din = v[k];
			#8 lnk_clk_i = 1'b1;
			#16 lnk_clk_i = 1'b0;
			#2;
			if (k < 8) begin
				chk("ss_dout", v[k], dout);
			end
			#6;
		end
		repeat (8) @(posedge ref_clk_i);
		chk("ss_byte", 8'hC9, got[0]);
	endtask

	initial begin
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		ms(1'b0);
		ms(1'b1);
		mp();
		mps();
		ap();
		ss();
		print_verdict();
	end
endmodule
